// ### dv/ccrc_link_model.sv
// Far-end control channel master model driving the serial link pins.
`timescale 1ns/1ps
module ccrc_link_model #(
  parameter int HALF_NS = 400
) (
  // Control from the bench.
  input  wire logic         run,
  input  wire logic [4:0]   first_frame,
  input  wire logic [255:0] frame_bytes,
  // Link pins.
  output      logic         serial_clock_input,
  output      logic         frame_sync_input,
  output      logic         control_serial_in
);
  logic [4:0] frame_num;
  // The clock stands high until the bench starts the stream.
  initial begin
    serial_clock_input = 1'b1;
    frame_sync_input = 1'b0;
    control_serial_in = 1'b1;
    frame_num = 5'h00;
    wait (run);
    // Keep link edges off the system clock edges so the synchroniser sees settled pins.
    #(HALF_NS / 16);
    frame_sync_input = 1'b1;
    control_serial_in = 1'b0;
    #(HALF_NS) serial_clock_input = 1'b0;
    #(HALF_NS) serial_clock_input = 1'b1;
    frame_sync_input = 1'b0;
    frame_num = first_frame;
    forever begin
      for (int i = 7; i >= 0; i--) begin
        control_serial_in = frame_bytes[frame_num * 8 + i];
        #(HALF_NS) serial_clock_input = 1'b0;
        #(HALF_NS) serial_clock_input = 1'b1;
      end
      frame_num = frame_num + 5'h01;
    end
  end
endmodule

// ### dv/control_channel_reflect_config_tb_top.sv
// Self-checking testbench of the control channel reflect block.
`timescale 1ns/1ps
module control_channel_reflect_config_tb_top;
  logic         clk;
  logic         resetn;
  logic [7:0]   addr;
  logic [7:0]   wdata;
  logic         wr;
  logic         rd;
  logic [7:0]   rdata;
  logic         tl_hi;
  logic         tl_lo;
  logic         sclk;
  logic         sync;
  logic         sdin;
  logic         sdout;
  logic         obc;
  logic         ev;
  int           ev_cnt;
  logic [31:0]  dis_bits;
  logic [31:0]  flex_bits;
  logic         run;
  logic [255:0] frame_bytes;
  int           fails;
  int           checked;

  ccrc_core u_dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .serial_clock_input(sclk),
    .frame_sync_input(sync), .control_serial_in(sdin),
    .tail_length_select_hi(tl_hi), .tail_length_select_lo(tl_lo),
    .control_serial_out(sdout), .output_buffer_control(obc),
    .channel_disable_bit(dis_bits), .flexible_control_bit(flex_bits),
    .frame_event(ev)
  );

  // Counts interrupt condition pulses between checks.
  always @(posedge clk) begin
    if (ev === 1'b1) begin
      ev_cnt++;
    end
  end

  ccrc_link_model u_link (
    .run(run), .first_frame(5'h05), .frame_bytes(frame_bytes),
    .serial_clock_input(sclk), .frame_sync_input(sync),
    .control_serial_in(sdin)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test;
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check({24'h0, rdata}, {24'h0, e});
  endtask

  // Frame n: bit4 = n[0], bits 2..0 = n[1], n[2], n[3]; bit7 is the loop bit.
  function automatic logic [7:0] byte_of(input logic [4:0] n,
                                         input logic inv, input logic loop);
    byte_of = {3'b000, n[0], 1'b0, n[1], n[2], n[3]} ^ (inv ? 8'h7F : 8'h00);
    byte_of[7] = loop;
  endfunction

  task automatic set_bytes(input logic inv, input logic loop);
    for (int n = 0; n < 32; n++) begin
      frame_bytes[n * 8 +: 8] <= byte_of(n[4:0], inv, (n == 3) && loop);
    end
  endtask

  task automatic chk_bits(input logic [1:0] sel, input logic inv);
    logic [31:0] ed;
    logic [31:0] ef;
    logic [7:0]  b;
    for (int n = 0; n < 32; n++) begin
      b = byte_of(n[4:0], inv, 1'b0);
      ed[n] = (n != 3) && b[4];
      ef[n] = (n != 3) && (sel == 2'b11 ? b[2] : sel == 2'b10 ? b[1] :
                           sel == 2'b01 ? b[0] : 1'b0);
    end
    check(dis_bits, ed);
    check(flex_bits, ef);
  endtask

  task automatic wait_cycle;
    repeat (2100) @(posedge clk);
  endtask

  task automatic chk_reflect;
    @(negedge sclk);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({31'h0, sdout}, {31'h0, sdin});
  endtask

  initial begin
    fails = 0;
    checked = 0;
    ev_cnt = 0;
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    tl_hi = 1'b0;
    tl_lo = 1'b0;
    run = 1'b0;
    frame_bytes = '0;
    set_bytes(1'b0, 1'b0);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(ccrc_pkg::CONFIG_ADDR, 8'h00);
    rd_reg(ccrc_pkg::ALIGN_ADDR, 8'h00);
    wr_reg(ccrc_pkg::CONFIG_ADDR, 8'h3C);
    rd_reg(ccrc_pkg::CONFIG_ADDR, 8'h00);
    wr_reg(ccrc_pkg::UNLOCK_ADDR, 8'h01);
    wr_reg(ccrc_pkg::ALIGN_ADDR, 8'h05);
    wr_reg(ccrc_pkg::SETUP_ADDR, 8'h03);
    wr_reg(ccrc_pkg::CONFIG_ADDR, 8'h3C);
    rd_reg(ccrc_pkg::CONFIG_ADDR, 8'h3C);
    rd_reg(ccrc_pkg::ALIGN_ADDR, 8'h05);
    rd_reg(8'h70, 8'h00);
    run <= 1'b1;
    wait_cycle();
    check({31'h0, obc}, 32'h0);
    for (int n = 0; n < 32; n++) begin
      rd_reg(8'h80 | n[7:0], byte_of(n[4:0], 1'b0, 1'b0));
    end
    chk_bits(2'b11, 1'b0);
    for (int s = 2; s >= 0; s--) begin
      wr_reg(ccrc_pkg::CONFIG_ADDR, 8'h30 | {4'h0, s[1:0], 2'b00});
      wait_cycle();
      chk_bits(s[1:0], 1'b0);
    end
    wr_reg(ccrc_pkg::CONFIG_ADDR, 8'h3D);
    rd_reg(8'h6C, 8'h0C);
    set_bytes(1'b1, 1'b0);
    wait_cycle();
    chk_bits(2'b00, 1'b0);
    rd_reg(8'h80, byte_of(5'h00, 1'b0, 1'b0));
    chk_reflect();
    wr_reg(ccrc_pkg::CONFIG_ADDR, 8'h3F);
    rd_reg(8'h6C, 8'h09);
    ev_cnt = 0;
    wait_cycle();
    chk_bits(2'b11, 1'b1);
    check({31'h0, ev_cnt != 0}, 32'h1);
    set_bytes(1'b1, 1'b1);
    wait_cycle();
    rd_reg(8'h6C, 8'h0A);
    chk_reflect();
    set_bytes(1'b0, 1'b1);
    ev_cnt = 0;
    wait_cycle();
    check(ev_cnt, 32'h0);
    rd_reg(8'h83, byte_of(5'h03, 1'b1, 1'b1));
    chk_bits(2'b11, 1'b1);
    set_bytes(1'b0, 1'b0);
    wait_cycle();
    rd_reg(8'h6C, 8'h09);
    rd_reg(8'h83, byte_of(5'h03, 1'b0, 1'b0));
    wr_reg(ccrc_pkg::CONFIG_ADDR, 8'h1E);
    repeat (4) @(posedge clk);
    check({31'h0, obc}, 32'h1);
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule

// ### pkg/ccrc_pkg.sv
// Constants, register layouts and types of the control channel reflect block.
// Operation
// - Listen enable only matters while reflection is active, whatever started it.
// - Reflecting with listen set: incoming frames are stored and signalled.
// - Reflecting with listen clear: no storing, only unmasked loop bit changes signalled; in hardware reflection code also signals a masked loop fall.
// - Driver control on: buffer control active only during processed channels, or in every frame with extended frame enable.
// - Driver control off: buffer control held high in every frame.
// - Hardware disable on: bit 4 of each channel frame disables that channel.
// - Flexible bit from frame bit 2, 1, 0 for selector 11, 10, 01; 00 off.
// - Loop bit handled by hardware only with loop enable and special frame mode.
// - Loop bit rising starts reflection at the next per-channel frame.
// - Triggering special frame stored last; later special frames not stored.
// - During hardware reflection with listen clear only unmasked loop bit changes are signalled; code also signals a masked loop fall via the stored frame.
// - Entering hardware reflection freezes all disable and flexible bits.
// - Loop bit falling ends reflection next frame; that special frame is stored.
// - Loop enable clear: normal operation, reflection under software control.
// - Software reflect bit honoured only with loop enable clear; acts immediately.
// - Software reflection with listen clear signals only loop changes; it always freezes channel bits.
// - In the 128 ms mode only the 16 processed channels are evaluated.
// - Next complete frame after sync gets the number in the alignment register.
// - Numbering aligns to first sync pulse seen at a serial clock falling edge.
// - Special frame mode: the selected frame carries global information.
// - No special frame set: the selected frame is an ordinary channel frame.
package ccrc_pkg;

  localparam logic [7:0] CONFIG_ADDR      = 8'h60;
  localparam logic [7:0] ALIGN_ADDR       = 8'h61;
  localparam logic [7:0] SETUP_ADDR       = 8'h68;
  localparam logic [7:0] MASK_ADDR        = 8'h69;
  localparam logic [7:0] UNLOCK_ADDR      = 8'h6A;
  localparam logic [7:0] STATUS_ADDR      = 8'h6B;
  localparam logic [2:0] RAM_WINDOW_BASE  = 3'h4;

  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [4:0] ALIGN_RESET      = 5'h00;
  localparam logic [7:0] SETUP_RESET      = 8'h00;

  localparam int         LOOP_BIT_POS     = 7;
  localparam int         DISABLE_BIT_POS  = 4;
  localparam int         CHANNELS         = 32;
  localparam logic [4:0] PROCESSED_128    = 5'h10;
  localparam logic [2:0] FIRST_BIT        = 3'h7;

  // Configuration register layout, bit 7 reads zero.
  typedef struct packed {
    logic       reserved;
    logic       reflect_listen_enable;
    logic       output_driver_control_enable;
    logic       hardware_disable_bit_enable;
    logic [1:0] flexible_bit_select;
    logic       hardware_loop_enable;
    logic       software_reflect_control;
  } ccrc_config_t;

  // Special frame setup, bit 7 reads zero.
  typedef struct packed {
    logic       reserved;
    logic       no_special_frame;
    logic       extended_frame_enable;
    logic [4:0] special_frame_select;
  } ccrc_setup_t;

  // Synchronised link pins.
  typedef struct packed {
    logic serial_clock_input;
    logic frame_sync_input;
    logic control_serial_in;
  } ccrc_link_t;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_HW     = 3'b010,
    ST_SW     = 3'b100
  } ccrc_state_t;

endpackage

// ### rtl/ccrc_core.sv
// Control channel reflect, frame alignment and channel bit logic.
`timescale 1ns/1ps
module ccrc_core #(
  parameter int CHANNELS = 32
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                resetn,
  // Register port.
  input  wire logic [7:0]          addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output      logic [7:0]          rdata,
  // Link pins.
  input  wire logic                serial_clock_input,
  input  wire logic                frame_sync_input,
  input  wire logic                control_serial_in,
  input  wire logic                tail_length_select_hi,
  input  wire logic                tail_length_select_lo,
  output      logic                control_serial_out,
  output      logic                output_buffer_control,
  // Channel control and events.
  output      logic [CHANNELS-1:0] channel_disable_bit,
  output      logic [CHANNELS-1:0] flexible_control_bit,
  output      logic                frame_event
);

  ccrc_pkg::ccrc_link_t   link_s1;
  ccrc_pkg::ccrc_link_t   link_s2;
  logic                   sclk_d;
  logic [1:0]             mode_s1;
  logic [1:0]             mode_s2;

  ccrc_pkg::ccrc_config_t cfg;
  ccrc_pkg::ccrc_config_t next_cfg;
  ccrc_pkg::ccrc_setup_t  setup;
  ccrc_pkg::ccrc_setup_t  next_setup;
  ccrc_pkg::ccrc_state_t  state;
  ccrc_pkg::ccrc_state_t  next_state;
  logic [4:0]             align;
  logic [4:0]             next_align;
  logic                   loop_mask;
  logic                   next_loop_mask;
  logic                   unlock;
  logic                   next_unlock;
  logic [2:0]             bit_cnt;
  logic [2:0]             next_bit_cnt;
  logic [4:0]             frame_num;
  logic [4:0]             next_frame_num;
  logic [6:0]             shift;
  logic [6:0]             next_shift;
  logic                   aligned;
  logic                   next_aligned;
  logic                   loop_prev;
  logic                   next_loop_prev;
  logic [CHANNELS-1:0]    next_dis;
  logic [CHANNELS-1:0]    next_flx;
  logic                   next_event;
  logic                   next_sout;
  logic                   next_tbuf;
  logic [7:0]             next_rdata;
  logic                   ram_we;
  logic [7:0]             ram_wd;
  logic [7:0]             input_frame_ram [CHANNELS];

  logic                   sclk_fall;
  logic                   frame_end;
  logic [7:0]             byte_in;
  logic                   mode_128;
  logic                   special;
  logic                   hw_active;
  logic                   evaluated;
  logic                   drive_ok;
  logic                   loop_rise;
  logic                   loop_fall;
  logic                   flex_val;
  logic                   store;

  // Pins from the link side pass two flip-flops before use.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_s1 <= '0;
      link_s2 <= '0;
      sclk_d  <= 1'b0;
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
    end else begin
      link_s1 <= {serial_clock_input, frame_sync_input, control_serial_in};
      link_s2 <= link_s1;
      sclk_d  <= link_s2.serial_clock_input;
      mode_s1 <= {tail_length_select_hi, tail_length_select_lo};
      mode_s2 <= mode_s1;
    end
  end

  always_comb begin
    sclk_fall = sclk_d & ~link_s2.serial_clock_input;
    frame_end = sclk_fall & aligned & (bit_cnt == 3'h0);
    byte_in   = {shift, link_s2.control_serial_in};
    mode_128  = mode_s2[1];
    special   = ~setup.no_special_frame
                & (frame_num == setup.special_frame_select);
    hw_active = cfg.hardware_loop_enable & ~setup.no_special_frame;
    evaluated = ~mode_128 | (frame_num < ccrc_pkg::PROCESSED_128);
    drive_ok  = evaluated | setup.extended_frame_enable;
    loop_rise = byte_in[ccrc_pkg::LOOP_BIT_POS] & ~loop_prev;
    loop_fall = ~byte_in[ccrc_pkg::LOOP_BIT_POS] & loop_prev;
    case (cfg.flexible_bit_select)
      2'h3:    flex_val = byte_in[2];
      2'h2:    flex_val = byte_in[1];
      2'h1:    flex_val = byte_in[0];
      default: flex_val = 1'b0;
    endcase
  end

  // Frame assembly, reflection state and channel bits.
  always_comb begin
    next_bit_cnt   = bit_cnt;
    next_frame_num = frame_num;
    next_shift     = shift;
    next_aligned   = aligned;
    next_loop_prev = loop_prev;
    next_state     = state;
    next_dis       = channel_disable_bit;
    next_flx       = flexible_control_bit;
    next_event     = 1'b0;
    ram_we         = 1'b0;
    ram_wd         = byte_in;
    store          = 1'b0;
    if (!cfg.hardware_loop_enable) begin
      // Software reflection acts at once, the loop bit is ignored.
      next_state = cfg.software_reflect_control ? ccrc_pkg::ST_SW
                                                : ccrc_pkg::ST_NORMAL;
    end else if (state == ccrc_pkg::ST_SW || !hw_active) begin
      next_state = ccrc_pkg::ST_NORMAL;
    end
    if (sclk_fall && !aligned && link_s2.frame_sync_input) begin
      next_aligned   = 1'b1;
      next_bit_cnt   = ccrc_pkg::FIRST_BIT;
      next_frame_num = align;
    end else if (sclk_fall && aligned) begin
      next_shift   = byte_in[6:0];
      next_bit_cnt = bit_cnt - 3'h1;
      if (frame_end) begin
        next_frame_num = frame_num + 5'h1;
        if (special) begin
          next_loop_prev = byte_in[ccrc_pkg::LOOP_BIT_POS];
          if (hw_active && loop_rise && state == ccrc_pkg::ST_NORMAL) begin
            next_state = ccrc_pkg::ST_HW;
          end
          if (state == ccrc_pkg::ST_HW && loop_fall) begin
            next_state = ccrc_pkg::ST_NORMAL;
          end
          case (state)
            ccrc_pkg::ST_HW: store = loop_fall;
            ccrc_pkg::ST_SW: store = cfg.reflect_listen_enable;
            default:         store = 1'b1;
          endcase
          next_event = (loop_rise | loop_fall) & ~loop_mask;
        end else begin
          store = state == ccrc_pkg::ST_NORMAL
                  | cfg.reflect_listen_enable;
          if (state == ccrc_pkg::ST_NORMAL && evaluated) begin
            // Reflection freezes these bits.
            next_dis[frame_num] = cfg.hardware_disable_bit_enable
                & byte_in[ccrc_pkg::DISABLE_BIT_POS];
            next_flx[frame_num] = flex_val;
          end
        end
        ram_we = store;
        if (store && byte_in != input_frame_ram[frame_num]) begin
          next_event = 1'b1;
        end
      end
    end
    next_sout = (state != ccrc_pkg::ST_NORMAL)
                ? link_s2.control_serial_in : 1'b1;
    next_tbuf = ~(cfg.output_driver_control_enable & aligned
                  & drive_ok);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt               <= ccrc_pkg::FIRST_BIT;
      frame_num             <= 5'h00;
      shift                 <= 7'h00;
      aligned               <= 1'b0;
      loop_prev             <= 1'b0;
      state                 <= ccrc_pkg::ST_NORMAL;
      channel_disable_bit   <= '0;
      flexible_control_bit  <= '0;
      frame_event           <= 1'b0;
      control_serial_out    <= 1'b1;
      output_buffer_control <= 1'b1;
    end else begin
      bit_cnt               <= next_bit_cnt;
      frame_num             <= next_frame_num;
      shift                 <= next_shift;
      aligned               <= next_aligned;
      loop_prev             <= next_loop_prev;
      state                 <= next_state;
      channel_disable_bit   <= next_dis;
      flexible_control_bit  <= next_flx;
      frame_event           <= next_event;
      control_serial_out    <= next_sout;
      output_buffer_control <= next_tbuf;
    end
  end

  always_ff @(posedge clk) begin
    if (ram_we) begin
      input_frame_ram[frame_num] <= ram_wd;
    end
  end

  // Register port.
  always_comb begin
    next_cfg       = cfg;
    next_align     = align;
    next_setup     = setup;
    next_loop_mask = loop_mask;
    next_unlock    = unlock;
    next_rdata     = 8'h00;
    if (wr) begin
      case (addr)
        ccrc_pkg::CONFIG_ADDR: if (unlock) begin
          next_cfg          = wdata;
          next_cfg.reserved = 1'b0;
        end
        ccrc_pkg::ALIGN_ADDR:  if (unlock) begin
          next_align = wdata[4:0];
        end
        ccrc_pkg::SETUP_ADDR: begin
          next_setup          = wdata;
          next_setup.reserved = 1'b0;
        end
        ccrc_pkg::MASK_ADDR:   next_loop_mask = wdata[0];
        ccrc_pkg::UNLOCK_ADDR: next_unlock = wdata[0];
        default:               next_unlock = unlock;
      endcase
    end
    if (rd) begin
      case (addr)
        ccrc_pkg::CONFIG_ADDR: next_rdata = cfg;
        ccrc_pkg::ALIGN_ADDR:  next_rdata = {3'h0, align};
        ccrc_pkg::SETUP_ADDR:  next_rdata = setup;
        ccrc_pkg::MASK_ADDR:   next_rdata = {7'h00, loop_mask};
        ccrc_pkg::UNLOCK_ADDR: next_rdata = {7'h00, unlock};
        ccrc_pkg::STATUS_ADDR: next_rdata = {2'h0, mode_128, frame_num};
        default: begin
          if (addr[7:5] == ccrc_pkg::RAM_WINDOW_BASE) begin
            next_rdata = input_frame_ram[addr[4:0]];
          end else if (addr == (ccrc_pkg::STATUS_ADDR + 8'h01)) begin
            next_rdata = {4'h0, aligned, state};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg       <= ccrc_pkg::CONFIG_RESET;
      align     <= ccrc_pkg::ALIGN_RESET;
      setup     <= ccrc_pkg::SETUP_RESET;
      loop_mask <= 1'b0;
      unlock    <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      cfg       <= next_cfg;
      align     <= next_align;
      setup     <= next_setup;
      loop_mask <= next_loop_mask;
      unlock    <= next_unlock;
      rdata     <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  listen_gate_a: assert property (
    frame_end && !special && state != ccrc_pkg::ST_NORMAL
    && !cfg.reflect_listen_enable |-> !ram_we)
    else $error("frame stored while reflecting without listen");

  buffer_off_a: assert property (
    !cfg.output_driver_control_enable |=> output_buffer_control)
    else $error("buffer control active with driver control off");

  hw_start_a: assert property (
    frame_end && special && hw_active && loop_rise
    && state == ccrc_pkg::ST_NORMAL |=> state == ccrc_pkg::ST_HW)
    else $error("loop bit rise did not start reflection");

  hw_stop_a: assert property (
    frame_end && special && state == ccrc_pkg::ST_HW && loop_fall
    && cfg.hardware_loop_enable |-> ram_we ##1 state == ccrc_pkg::ST_NORMAL)
    else $error("loop bit fall did not end reflection");

  special_hold_a: assert property (
    frame_end && special && state == ccrc_pkg::ST_HW && !loop_fall
    |-> !ram_we)
    else $error("special frame stored during reflection");

  bits_frozen_a: assert property (
    state != ccrc_pkg::ST_NORMAL |=> $stable(channel_disable_bit)
    && $stable(flexible_control_bit))
    else $error("channel bits changed while reflecting");

  sw_ignored_a: assert property (
    cfg.hardware_loop_enable |=> state != ccrc_pkg::ST_SW)
    else $error("software reflection with loop enable set");

  flex_off_a: assert property (
    frame_end && !special && state == ccrc_pkg::ST_NORMAL
    && cfg.flexible_bit_select == 2'h0
    |=> !flexible_control_bit[$past(frame_num)])
    else $error("flexible bit set with selector zero");

  config_lock_a: assert property (
    wr && addr == ccrc_pkg::CONFIG_ADDR && !unlock |=> $stable(cfg))
    else $error("locked configuration register was written");

  align_number_a: assert property (
    sclk_fall && !aligned && link_s2.frame_sync_input
    |=> aligned && frame_num == $past(align) && bit_cnt == 3'h7)
    else $error("frame numbering not aligned to sync");

  hw_reflect_c: cover property (
    state == ccrc_pkg::ST_HW ##[1:1000] state == ccrc_pkg::ST_NORMAL);
  sw_reflect_c: cover property (state == ccrc_pkg::ST_SW && frame_end);
  event_c: cover property (frame_event && state != ccrc_pkg::ST_NORMAL);

endmodule
